// ===== bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic conv_req = 1'b0;
  logic rd_req = 1'b0;
  logic sel = 1'b0;
  logic [8:0] flash_code = 9'h000;
  logic conversion_start_n, cs_n, rd_n, upper_byte_select, hold, busy_n, res_hold;
  logic [15:0] dac_code, data_out, data_oe;
  logic [7:0] byte_out, byte_oe;
  logic [31:0] seed = 32'h0000_a525;
  // Negative limit, positive limit, midscale
  logic [8:0] coarse_tab [3] = '{9'h100, 9'h0ff, 9'h000};
  logic [8:0] fine_tab [3] = '{9'h000, 9'h1ff, 9'h080};
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  initial begin
    forever #10 clk = ~clk;
  end
  tpadc_seq DUT (.clk(clk), .resetn(resetn), .conversion_start_n(conversion_start_n), .cs_n(cs_n),
    .rd_n(rd_n), .upper_byte_select(upper_byte_select), .flash_code(flash_code), .hold(hold),
    .busy_n(busy_n), .dac_code(dac_code), .res_hold(res_hold), .data_out(data_out),
    .data_oe(data_oe), .byte_out(byte_out), .byte_oe(byte_oe));
  tpadc_host host (.clk(clk), .busy_n(busy_n), .conv_req(conv_req), .rd_req(rd_req), .sel(sel),
    .conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_n(rd_n),
    .upper_byte_select(upper_byte_select));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // Offset binary sum, clipped, then top bit flipped for twos complement
  function automatic logic [15:0] exp_word(input logic [8:0] c, input logic [8:0] f);
    int s;
    s = int'({~c[8], c[7:0]}) * 32'h0000_0080 + int'(f) - 32'h0000_0080;
    if (s < 0) s = 0;
    if (s > 32'h0000_ffff) s = 32'h0000_ffff;
    return 16'(s) ^ 16'h8000;
  endfunction : exp_word
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    num_checks++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic close_out();
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic convert(input logic [8:0] c, input logic [8:0] f);
    @(posedge clk);
    flash_code <= c;
    conv_req <= 1'b1;
    @(posedge clk);
    conv_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(16'(busy_n), 16'h0000);
    chk(16'(hold), 16'h0000);
    @(posedge clk);
    #1;
    chk(16'(hold), 16'h0001);
    repeat (400) begin
      @(posedge clk);
      #1;
      if (res_hold === 1'b1) break;
    end
    chk(16'(res_hold), 16'h0001);
    chk(16'(hold), 16'h0000);
    chk(dac_code, {c, 7'h00});
    @(posedge clk);
    flash_code <= f;
    repeat (200) begin
      @(posedge clk);
      #1;
      if (busy_n === 1'b1) break;
    end
    chk(16'(busy_n), 16'h0001);
    chk(16'(res_hold), 16'h0000);
  endtask : convert
  task automatic rd(input logic s, input logic [15:0] w);
    @(posedge clk);
    sel <= s;
    rd_req <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(data_out, w);
    chk(data_oe, 16'hffff);
    chk({8'h00, byte_out}, {8'h00, s ? w[15:8] : w[7:0]});
    chk({8'h00, byte_oe}, 16'h00ff);
    @(posedge clk);
    rd_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(data_oe, 16'h0000);
  endtask : rd
  ////////////////////////////////////////////////////////////////
  // Seven conversions take about 2000 cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    logic [8:0] c;
    logic [8:0] f;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk(16'(busy_n), 16'h0001);
    chk(16'(hold), 16'h0000);
    chk(data_oe, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      seed = xs(seed);
      c = (i < 3) ? coarse_tab[i] : seed[8:0];
      f = (i < 3) ? fine_tab[i] : seed[24:16];
      convert(c, f);
      rd(1'b0, exp_word(c, f));
      rd(1'b1, exp_word(c, f));
    end
    close_out();
  end
endmodule : tb_top

// ===== bench/tpadc_host.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////
module tpadc_host (
  input wire logic clk,
  input wire logic busy_n,
  input wire logic conv_req,
  input wire logic rd_req,
  input wire logic sel,
  output logic conversion_start_n,
  output logic cs_n,
  output logic rd_n,
  output logic upper_byte_select
);
  initial begin
    conversion_start_n = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    upper_byte_select = 1'b0;
  end
  // Requests are held back while busy, so a start always sees one low sample first
  always @(posedge clk) begin
    conversion_start_n <= !(conv_req && busy_n);
    cs_n <= !(rd_req && busy_n);
    rd_n <= !(rd_req && busy_n);
    upper_byte_select <= sel;
  end
endmodule : tpadc_host

// ===== verilog/tpadc_corr.sv
`timescale 1ns/100ps
module tpadc_corr (
  input wire logic [8:0] coarse,
  input wire logic [8:0] fine,
  output logic [15:0] word
);
  logic [16:0] sum;
  logic [9:0] fine_adj;
  always_comb begin
    // Residue carries an offset so a coarse error of either sign stays in range
    fine_adj = {1'b0, fine} - {1'b0, tpadc_pkg::RESIDUE_OFFSET};
    // Coarse is twos complement; flipping the top bit gives offset binary
    sum = {1'b0, ~coarse[8], coarse[7:0], tpadc_pkg::DAC_LOW_ZERO}
      + {{7{fine_adj[9]}}, fine_adj};
    // Bit 16 flags a result outside the word; the residue sign tells which end it left by
    if (sum[16] && !fine_adj[9]) begin
      word = 16'h7fff;
    end else if (sum[16]) begin
      word = 16'h8000;
    end else begin
      word = sum[15:0] ^ 16'h8000;
    end
  end
endmodule : tpadc_corr

// ===== verilog/tpadc_pkg.sv
package tpadc_pkg;
  // Clock and timing
  localparam int unsigned CLK_PERIOD_PS = 20000;
  localparam int unsigned HOLD_DELAY_PS = 50000;
  localparam int unsigned PASS1_TIME_PS = 3350000;
  localparam int unsigned CONV_TIME_PS = 5300000;
  // Least times round up, never below one cycle
  localparam int unsigned HOLD_DELAY_CYC = (HOLD_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PASS1_CYC = (PASS1_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CONV_CYC = (CONV_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CORR_CYC = 2;
  localparam int unsigned CNT_W = 9;
  // Word layout
  localparam int unsigned WORD_W = 16;
  localparam int unsigned PASS_W = 9;
  localparam int unsigned DAC_LOW_W = 7;
  localparam int unsigned BYTE_W = 8;
  // Residue offset inserted by the amplifier, one quarter of the second pass range
  localparam logic [8:0] RESIDUE_OFFSET = 9'h080;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [6:0] DAC_LOW_ZERO = 7'h00;
  // Spans in microvolts, code step in nanovolts; the scaled span overflows 32 bits, so widen first
  localparam int unsigned SPAN_NARROW_UV = 6000000;
  localparam int unsigned SPAN_WIDE_UV = 10000000;
  localparam int unsigned LSB_NARROW_NV = int'((longint'(SPAN_NARROW_UV) * 64'h0000_0000_0000_03e8) >> WORD_W);
  localparam int unsigned LSB_WIDE_NV = int'((longint'(SPAN_WIDE_UV) * 64'h0000_0000_0000_03e8) >> WORD_W);
endpackage : tpadc_pkg

// ===== verilog/tpadc_seq.sv
// What this block does
// - Start rising edge: hold after fixed delay
// - First pass lasts fixed time
// - First pass gives nine MSBs to DAC
// - DAC low seven bits always zero
// - Second pass digitises residue after settling
// - Correction removes offset, merges passes
// - Track again when second pass starts
// - Output word is twos complement
// - Code step is span over 65536
// - Busy low from start until result
// - Chip select and read drive data
// - Byte select chooses upper or lower
`timescale 1ns/100ps
module tpadc_seq (
  input wire logic clk,
  input wire logic resetn,
  input wire logic conversion_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic upper_byte_select,
  input wire logic [8:0] flash_code,
  output logic hold,
  output logic busy_n,
  output logic [15:0] dac_code,
  output logic res_hold,
  output logic [15:0] data_out,
  output logic [15:0] data_oe,
  output logic [7:0] byte_out,
  output logic [7:0] byte_oe
);
  typedef enum logic [2:0] {IDLE, APERTURE, PASS1, PASS2, CORRECT} tpadc_state_t;
  tpadc_state_t state_r;
  logic start_d_r;
  logic [tpadc_pkg::CNT_W-1:0] cnt_r;
  logic [8:0] coarse_r;
  logic [8:0] fine_r;
  logic [15:0] word_r;
  logic [15:0] corr_word;
  logic start_edge;
  logic cnt_done;
  logic reading;

  assign start_edge = conversion_start_n && !start_d_r;
  assign cnt_done = cnt_r == '0;
  assign reading = !cs_n && !rd_n;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_d_r <= 1'b1;
    end else begin
      start_d_r <= conversion_start_n;
    end
  end

  // A start during a conversion is ignored; the host must wait for busy
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= IDLE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        IDLE: begin
          if (start_edge) begin
            state_r <= APERTURE;
            cnt_r <= tpadc_pkg::CNT_W'(tpadc_pkg::HOLD_DELAY_CYC - 1);
          end
        end
        APERTURE: begin
          if (cnt_done) begin
            state_r <= PASS1;
            cnt_r <= tpadc_pkg::CNT_W'(tpadc_pkg::PASS1_CYC - tpadc_pkg::HOLD_DELAY_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        PASS1: begin
          if (cnt_done) begin
            state_r <= PASS2;
            cnt_r <= tpadc_pkg::CNT_W'(tpadc_pkg::CONV_CYC - tpadc_pkg::PASS1_CYC - tpadc_pkg::CORR_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        PASS2: begin
          if (cnt_done) begin
            state_r <= CORRECT;
            cnt_r <= tpadc_pkg::CNT_W'(tpadc_pkg::CORR_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        CORRECT: begin
          if (cnt_done) begin
            state_r <= IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          state_r <= IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Track-and-hold and busy
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold <= 1'b0;
      busy_n <= 1'b1;
    end else begin
      if (state_r == APERTURE && cnt_done) begin
        hold <= 1'b1;
      end else if (state_r == PASS1 && cnt_done) begin
        hold <= 1'b0;
      end
      if (state_r == IDLE && start_edge) begin
        busy_n <= 1'b0;
      end else if (state_r == CORRECT && cnt_done) begin
        busy_n <= 1'b1;
      end
    end
  end

  // Residue amplifier holds during the second pass
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      res_hold <= 1'b0;
    end else begin
      res_hold <= (state_r == PASS1 && cnt_done) || (state_r == PASS2 && !cnt_done);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pass results; flash is sampled at the end of each pass
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      coarse_r <= '0;
      fine_r <= '0;
      dac_code <= tpadc_pkg::WORD_RESET;
    end else begin
      if (state_r == PASS1 && cnt_done) begin
        coarse_r <= flash_code;
        dac_code <= {flash_code, tpadc_pkg::DAC_LOW_ZERO};
      end
      if (state_r == PASS2 && cnt_done) begin
        fine_r <= flash_code;
      end
    end
  end

  tpadc_corr u_corr (
    .coarse(coarse_r),
    .fine(fine_r),
    .word(corr_word)
  );

  // Step is span/2^16 whichever range the analog front end uses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_r <= tpadc_pkg::WORD_RESET;
    end else if (state_r == CORRECT && cnt_done) begin
      word_r <= corr_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port; data shows one cycle after the strobes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_out <= tpadc_pkg::WORD_RESET;
      data_oe <= '0;
      byte_out <= '0;
      byte_oe <= '0;
    end else begin
      data_out <= word_r;
      data_oe <= {tpadc_pkg::WORD_W{reading}};
      byte_out <= upper_byte_select ? word_r[15:8] : word_r[7:0];
      byte_oe <= {tpadc_pkg::BYTE_W{reading}};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_start;
    state_r == IDLE && start_edge;
  endsequence
  sequence s_hold_on;
    !hold [*3] ##1 hold;
  endsequence

  AST_HOLD_DELAY: assert property (@(posedge clk) disable iff (!resetn)
    s_start |=> s_hold_on)
    else $error("Hold did not follow start by the aperture delay");
  AST_PASS1_LEN: assert property (@(posedge clk) disable iff (!resetn)
    $rose(hold) |-> hold [*8])
    else $error("First pass ended too early");
  AST_TRACK_AT_PASS2: assert property (@(posedge clk) disable iff (!resetn)
    $rose(res_hold) |-> $fell(hold))
    else $error("Track did not resume when second pass began");
  AST_DAC_LOW: assert property (@(posedge clk) disable iff (!resetn)
    dac_code[6:0] == 7'h00)
    else $error("DAC low bits not zero");
  AST_DAC_LOAD: assert property (@(posedge clk) disable iff (!resetn)
    $fell(hold) |-> dac_code[15:7] == $past(flash_code))
    else $error("DAC top bits not the first pass result");
  AST_BUSY_LOW: assert property (@(posedge clk) disable iff (!resetn)
    s_start |=> !busy_n [*8])
    else $error("Busy not low during conversion");
  AST_BUSY_END: assert property (@(posedge clk) disable iff (!resetn)
    $rose(busy_n) |-> word_r == $past(corr_word))
    else $error("Busy rose without the new result");
  AST_READ_DRIVE: assert property (@(posedge clk) disable iff (!resetn)
    reading |=> data_oe == 16'hffff && data_out == $past(word_r))
    else $error("Read did not drive the result");
  AST_BYTE_SEL: assert property (@(posedge clk) disable iff (!resetn)
    reading && upper_byte_select |=> byte_out == $past(word_r[15:8]))
    else $error("Upper byte not selected");
endmodule : tpadc_seq
